// File: rtc_wdog_pkg.sv
// Shared constants and carriers for the I/O-mapped calendar clock with watchdog.
// Assumes a single 100 MHz clock and an 8-bit processor I/O bus.
package rtc_wdog_pkg;

  // Clock rate and documented times
  localparam int CLK_HZ = 100_000_000;
  localparam int TICK_HZ = 64;                          // 1/64 s base tick
  localparam int TICK_CYCLES = CLK_HZ / TICK_HZ;
  localparam int PULSE_US = 7800;                       // 7.8 ms interrupt pulse
  localparam int PULSE_CYCLES = PULSE_US * (CLK_HZ / 1_000_000);
  localparam int WD_TIMEOUT_MS = 1420;                  // nominal watchdog timeout
  localparam int WD_CYCLES = WD_TIMEOUT_MS * (CLK_HZ / 1000);
  localparam int RST_HOLD_CYCLES = 16;                  // width of board reset request

  // Shared I/O window 40H..7FH
  localparam logic [7:0] WIN_BASE = 8'h40;
  localparam logic [7:0] WIN_MASK = 8'hc0;

  // Register index within the window (low four address bits)
  localparam logic [3:0] IDX_SEC_U = 4'h0;
  localparam logic [3:0] IDX_SEC_T = 4'h1;
  localparam logic [3:0] IDX_MIN_U = 4'h2;
  localparam logic [3:0] IDX_MIN_T = 4'h3;
  localparam logic [3:0] IDX_HOU_U = 4'h4;
  localparam logic [3:0] IDX_HOU_T = 4'h5;
  localparam logic [3:0] IDX_DAY_U = 4'h6;
  localparam logic [3:0] IDX_DAY_T = 4'h7;
  localparam logic [3:0] IDX_MON_U = 4'h8;
  localparam logic [3:0] IDX_MON_T = 4'h9;
  localparam logic [3:0] IDX_YEA_U = 4'ha;
  localparam logic [3:0] IDX_YEA_T = 4'hb;
  localparam logic [3:0] IDX_WEEK = 4'hc;
  localparam logic [3:0] IDX_CTRL_D = 4'hd;
  localparam logic [3:0] IDX_CTRL_E = 4'he;
  localparam logic [3:0] IDX_CTRL_F = 4'hf;
  localparam int NUM_DIGITS = 13;

  // Implemented bits of each digit register, index 12 (weekday) first
  localparam logic [12:0][3:0] DIGIT_MASK = {
    4'h7, 4'hf, 4'hf, 4'h1, 4'hf, 4'h3, 4'hf, 4'h7, 4'hf, 4'h7, 4'hf, 4'h7, 4'hf};

  // Field positions
  localparam int MERIDIEM_BIT = 2;                      // in hours tens
  localparam int D_ROUND_BIT = 3;
  localparam int D_FLAG_BIT = 2;
  localparam int D_BUSY_BIT = 1;
  localparam int D_COMMIT_BIT = 0;
  localparam int E_PERIOD_HI = 3;
  localparam int E_PERIOD_LO = 2;
  localparam int E_LATCH_BIT = 1;
  localparam int E_GATE_BIT = 0;
  localparam int F_TEST_BIT = 3;
  localparam int F_H24_BIT = 2;
  localparam int F_HALT_BIT = 1;
  localparam int F_DIVCLR_BIT = 0;
  localparam int JUMPER_BIT = 7;

  // Reset values of the control fields
  localparam logic [3:0] CTRL_E_RESET = 4'h0;
  localparam logic [2:0] CTRL_F_RESET = 3'h0;

  // Periodic interrupt period codes
  typedef enum logic [1:0] {
    PER_64TH = 2'h0,
    PER_SEC = 2'h1,
    PER_MIN = 2'h2,
    PER_HOUR = 2'h3
  } period_e;

  // One I/O bus request, all fields valid for one clock
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } io_req_s;

endpackage

// File: rtc_watchdog_io.sv
// Calendar clock, periodic interrupt, external watchdog and jumper sense,
// all decoded in one shared I/O window of the host processor.
// Assumes host strobes are synchronous to clk; jumper and board reset pins are
// asynchronous and are synchronised here. rstn is the backup-supply power-on reset.
`timescale 1ns/1ps

module rtc_watchdog_io #(
  parameter int TICK_CYC = rtc_wdog_pkg::TICK_CYCLES,
  parameter int PULSE_CYC = rtc_wdog_pkg::PULSE_CYCLES,
  parameter int WD_CYC = rtc_wdog_pkg::WD_CYCLES
) (
  // Clock and backup-supply reset
  input wire logic clk,
  input wire logic rstn,
  // Host I/O bus
  input rtc_wdog_pkg::io_req_s io_req,
  output logic [7:0] io_rdata,
  // Board pins
  input wire logic config_jumper_fitted,
  input wire logic watchdog_enable_jumper,
  input wire logic board_rst_n,
  // Outputs to the board
  output logic rtc_irq,
  output logic board_reset_req
);
  import rtc_wdog_pkg::*;

  typedef struct packed {
    logic [12:0][3:0] tm;
    logic [12:0][3:0] shadow;
    logic [12:0] dirty;
    logic irq_flag;
    logic commit_bit;
    logic [3:0] ctrl_e;
    logic [2:0] ctrl_f;
    logic [20:0] pre;
    logic [5:0] sub64;
    logic [19:0] pulse;
    logic [27:0] wd;
    logic [4:0] rst_hold;
    logic board_rst;
    logic [7:0] rdata;
    logic [1:0] jmp_sync;
    logic [1:0] wden_sync;
    logic [1:0] brst_sync;
  } rtc_state_s;

  rtc_state_s st;
  rtc_state_s next_st;

  // Window decode, mirrored on every 16-byte block
  function automatic logic win_hit(input io_req_s r, input logic [3:0] idx);
    win_hit = r.wr && ((r.addr & WIN_MASK) == WIN_BASE) && (r.addr[3:0] == idx);
  endfunction

  // Advance the calendar by one minute, carrying into hours, days, months, years
  function automatic logic [12:0][3:0] bump_minute(input logic [12:0][3:0] t,
                                                   input logic h24);
    logic [12:0][3:0] r;
    logic hc;
    logic dc;
    logic [7:0] mon;
    logic [7:0] dim;
    logic leap;
    r = t;
    hc = 1'b0;
    dc = 1'b0;
    if (r[2] != 4'h9)
      r[2] = r[2] + 4'h1;
    else
    begin
      r[2] = 4'h0;
      if (r[3] != 4'h5)
        r[3] = r[3] + 4'h1;
      else
      begin
        r[3] = 4'h0;
        hc = 1'b1;
      end
    end
    if (hc && h24)
    begin
      if (r[5][1:0] == 2'h2 && r[4] == 4'h3)
      begin
        r[5][1:0] = 2'h0;
        r[4] = 4'h0;
        dc = 1'b1;
      end
      else if (r[4] == 4'h9)
      begin
        r[4] = 4'h0;
        r[5][1:0] = r[5][1:0] + 2'h1;
      end
      else
        r[4] = r[4] + 4'h1;
    end
    else if (hc)
    begin
      // 12-hour mode: 11 -> 12 flips meridiem, 12 -> 1
      if (r[5][0] && r[4] == 4'h2)
      begin
        r[5][0] = 1'b0;
        r[4] = 4'h1;
      end
      else if (r[5][0] && r[4] == 4'h1)
      begin
        r[4] = 4'h2;
        dc = r[5][MERIDIEM_BIT];
        r[5][MERIDIEM_BIT] = ~r[5][MERIDIEM_BIT];
      end
      else if (r[4] == 4'h9)
      begin
        r[4] = 4'h0;
        r[5][0] = 1'b1;
      end
      else
        r[4] = r[4] + 4'h1;
    end
    // Month length from BCD month and year
    mon = {r[9], r[8]};
    leap = r[11][0] ? (r[10] == 4'h2 || r[10] == 4'h6)
                    : (r[10] == 4'h0 || r[10] == 4'h4 || r[10] == 4'h8);
    if (mon == 8'h02)
      dim = leap ? 8'h29 : 8'h28;
    else if (mon == 8'h04 || mon == 8'h06 || mon == 8'h09 || mon == 8'h11)
      dim = 8'h30;
    else
      dim = 8'h31;
    if (dc)
    begin
      r[12] = (r[12] == 4'h6) ? 4'h0 : r[12] + 4'h1;
      if ({r[7], r[6]} == dim)
      begin
        r[7] = 4'h0;
        r[6] = 4'h1;
        if (mon == 8'h12)
        begin
          r[9] = 4'h0;
          r[8] = 4'h1;
          if (r[10] == 4'h9)
          begin
            r[10] = 4'h0;
            r[11] = (r[11] == 4'h9) ? 4'h0 : r[11] + 4'h1;
          end
          else
            r[10] = r[10] + 4'h1;
        end
        else if (r[8] == 4'h9)
        begin
          r[8] = 4'h0;
          r[9] = 4'h1;
        end
        else
          r[8] = r[8] + 4'h1;
      end
      else if (r[6] == 4'h9)
      begin
        r[6] = 4'h0;
        r[7] = r[7] + 4'h1;
      end
      else
        r[6] = r[6] + 4'h1;
    end
    bump_minute = r;
  endfunction
  logic in_win, kick, wr_d, wr_e, wr_f, latched, busy;
  logic tick, sec_ev, min_ev, hour_ev, period_ev;
  logic [3:0] rd_val;
  // Bus decode and timebase events
  always_comb
  begin
    in_win = (io_req.addr & WIN_MASK) == WIN_BASE;
    kick = in_win && (io_req.rd || io_req.wr);
    wr_d = win_hit(io_req, IDX_CTRL_D);
    wr_e = win_hit(io_req, IDX_CTRL_E);
    wr_f = win_hit(io_req, IDX_CTRL_F);
    latched = st.ctrl_e[E_LATCH_BIT];
    // Halt stops the prescaler too; a divider clear costs the current tick
    if (st.ctrl_f[F_HALT_BIT - 1] || (wr_f && io_req.wdata[F_DIVCLR_BIT]))
      tick = 1'b0;
    else if (st.ctrl_f[F_TEST_BIT - 1])
      tick = 1'b1;
    else
      tick = st.pre == 21'(TICK_CYC - 1);
    sec_ev = tick && (st.sub64 == 6'h3f);
    min_ev = sec_ev && st.tm[1] == 4'h5 && st.tm[0] == 4'h9;
    hour_ev = min_ev && st.tm[3] == 4'h5 && st.tm[2] == 4'h9;
    unique case (period_e'(st.ctrl_e[E_PERIOD_HI:E_PERIOD_LO]))
      PER_64TH: period_ev = tick;
      PER_SEC: period_ev = sec_ev;
      PER_MIN: period_ev = min_ev;
      PER_HOUR: period_ev = hour_ev;
    endcase
    // Last 64th before a seconds rollover: counters are about to change
    busy = (st.sub64 == 6'h3f) && !st.ctrl_f[F_HALT_BIT - 1];
    unique case (io_req.addr[3:0])
      IDX_CTRL_D: rd_val = {1'b0, st.irq_flag, busy, st.commit_bit};
      IDX_CTRL_E: rd_val = st.ctrl_e;
      IDX_CTRL_F: rd_val = {st.ctrl_f, 1'b0};
      default: rd_val = st.tm[io_req.addr[3:0]] & DIGIT_MASK[io_req.addr[3:0]];
    endcase
  end

  // Next state
  always_comb
  begin
    next_st = st;
    next_st.jmp_sync = {st.jmp_sync[0], config_jumper_fitted};
    next_st.wden_sync = {st.wden_sync[0], watchdog_enable_jumper};
    next_st.brst_sync = {st.brst_sync[0], board_rst_n};

    // Prescaler chain
    if (wr_f && io_req.wdata[F_DIVCLR_BIT])
    begin
      next_st.pre = 21'h0;
      next_st.sub64 = 6'h0;
    end
    else if (!st.ctrl_f[F_HALT_BIT - 1])
    begin
      next_st.pre = (st.pre >= 21'(TICK_CYC - 1)) ? 21'h0 : st.pre + 21'h1;
      if (tick)
        next_st.sub64 = st.sub64 + 6'h1;
    end

    // Seconds count and carries
    if (sec_ev)
    begin
      if (st.tm[0] != 4'h9)
        next_st.tm[0] = st.tm[0] + 4'h1;
      else
      begin
        next_st.tm[0] = 4'h0;
        if (st.tm[1] != 4'h5)
          next_st.tm[1] = st.tm[1] + 4'h1;
        else
        begin
          next_st.tm[1] = 4'h0;
          next_st.tm = bump_minute(next_st.tm, st.ctrl_f[F_H24_BIT - 1]);
        end
      end
    end

    // Digit writes land in the staging copy until committed
    for (int i = 0; i < NUM_DIGITS; i++)
    begin
      if (win_hit(io_req, 4'(i)))
      begin
        next_st.shadow[i] = io_req.wdata[3:0] & DIGIT_MASK[i];
        next_st.dirty[i] = 1'b1;
      end
    end

    // Control D: commit first, so rounding in the same write acts on the new time
    if (wr_d)
    begin
      if (io_req.wdata[D_COMMIT_BIT])
      begin
        for (int i = 0; i < NUM_DIGITS; i++)
        begin
          if (st.dirty[i])
            next_st.tm[i] = st.shadow[i];
        end
        next_st.dirty = 13'h0;
      end
      if (io_req.wdata[D_ROUND_BIT])
      begin
        if (next_st.tm[1] >= 4'h3)
          next_st.tm = bump_minute(next_st.tm, st.ctrl_f[F_H24_BIT - 1]);
        next_st.tm[0] = 4'h0;
        next_st.tm[1] = 4'h0;
      end
      next_st.commit_bit = io_req.wdata[D_COMMIT_BIT];
      if (!io_req.wdata[D_FLAG_BIT] && latched)
        next_st.irq_flag = 1'b0;
    end
    if (wr_e)
      next_st.ctrl_e = io_req.wdata[3:0];
    if (wr_f)
      next_st.ctrl_f = io_req.wdata[3:1];

    // Pulse mode times itself out; a new period event always wins
    if (st.irq_flag && !latched)
    begin
      if (st.pulse == 20'h0)
        next_st.irq_flag = 1'b0;
      else
        next_st.pulse = st.pulse - 20'h1;
    end
    if (period_ev)
    begin
      next_st.irq_flag = 1'b1;
      next_st.pulse = 20'(PULSE_CYC - 1);
    end

    // Read data: jumper on bit 7, inverted; register value in low nibble
    if (io_req.rd && in_win)
      next_st.rdata = {~st.jmp_sync[1], 3'h0, rd_val};

    // External watchdog
    if (st.board_rst)
    begin
      if (st.rst_hold == 5'h0)
        next_st.board_rst = 1'b0;
      else
        next_st.rst_hold = st.rst_hold - 5'h1;
    end
    if (kick || !st.brst_sync[1])
      next_st.wd = 28'h0;
    else if (st.wden_sync[1] && st.wd >= 28'(WD_CYC - 1))
    begin
      next_st.wd = 28'h0;
      next_st.board_rst = 1'b1;
      next_st.rst_hold = 5'(RST_HOLD_CYCLES - 1);
    end
    else if (st.wden_sync[1])
      next_st.wd = st.wd + 28'h1;
  end

  // State register; only the backup-supply reset clears it, board reset clears just the watchdog count
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st <= '0;
      st.ctrl_e <= CTRL_E_RESET;
      st.ctrl_f <= CTRL_F_RESET;
      st.brst_sync <= 2'h3;
    end
    else
      st <= next_st;
  end
  assign io_rdata = st.rdata;
  assign rtc_irq = st.irq_flag && !st.ctrl_e[E_GATE_BIT];
  assign board_reset_req = st.board_rst;
  // Checks
  sequence s_wr_d;
    wr_d;
  endsequence
  a_jumper_read: assert property (@(posedge clk) disable iff (!rstn)
    io_req.rd && in_win |=> io_rdata[JUMPER_BIT] == !$past(st.jmp_sync[1]))
    else $error("jumper bit not inverted on read");
  a_kick_clears: assert property (@(posedge clk) disable iff (!rstn)
    kick |=> st.wd == 28'h0 ##1 st.wd <= 28'h1)
    else $error("watchdog not restarted by window access");
  a_gate_blocks: assert property (@(posedge clk) disable iff (!rstn)
    wr_e && io_req.wdata[E_GATE_BIT] |=> !rtc_irq)
    else $error("interrupt output not gated");
  a_latched_holds: assert property (@(posedge clk) disable iff (!rstn)
    st.irq_flag && latched && !wr_e && !wr_d |=> st.irq_flag)
    else $error("latched interrupt dropped on its own");
  a_pulse_load: assert property (@(posedge clk) disable iff (!rstn)
    period_ev |=> st.irq_flag && st.pulse == 20'(PULSE_CYC - 1))
    else $error("pulse timer not loaded on period event");
  a_halt_freeze: assert property (@(posedge clk) disable iff (!rstn)
    st.ctrl_f[F_HALT_BIT - 1] && !io_req.wr |=> $stable(st.tm) && $stable(st.sub64))
    else $error("time moved while halted");
  a_divider_clear: assert property (@(posedge clk) disable iff (!rstn)
    wr_f && io_req.wdata[F_DIVCLR_BIT] |=> st.pre == 21'h0 && st.sub64 == 6'h0)
    else $error("prescaler not cleared");
  a_round_secs: assert property (@(posedge clk) disable iff (!rstn)
    s_wr_d ##0 io_req.wdata[D_ROUND_BIT] |=> st.tm[0] == 4'h0 && st.tm[1] == 4'h0)
    else $error("seconds not cleared by rounding");
  a_commit_load: assert property (@(posedge clk) disable iff (!rstn)
    s_wr_d ##0 io_req.wdata[D_COMMIT_BIT] && st.dirty[2] && !io_req.wdata[D_ROUND_BIT]
      && !sec_ev |=> st.tm[2] == $past(st.shadow[2]) && st.dirty == 13'h0)
    else $error("staged digit not committed");
  a_wd_fire: assert property (@(posedge clk) disable iff (!rstn)
    st.wden_sync[1] && st.brst_sync[1] && !kick && st.wd == 28'(WD_CYC - 1)
      |=> board_reset_req [*8])
    else $error("board reset not raised on timeout");

endmodule

// File: io_host_model.sv
// Host processor model issuing single-cycle I/O reads and writes.
// Assumes the block samples its strobes on the rising edge of clk.
`timescale 1ns/1ps

module io_host_model (
  // Clock
  input wire logic clk,
  // I/O bus towards the block
  output rtc_wdog_pkg::io_req_s io_req,
  input wire logic [7:0] io_rdata
);
  import rtc_wdog_pkg::*;

  initial io_req = '0;

  // One strobe cycle; released lines show inverted values so stale data never passes
  task automatic cyc(input logic r, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    io_req <= '{rd: r, wr: !r, addr: a, wdata: d};
    @(posedge clk);
    io_req <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    cyc(1'b0, a, d);
  endtask

  // Read data is registered, so it is taken once the answering edge has settled
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    cyc(1'b1, a, 8'h00);
    #1 d = io_rdata;
  endtask

  // Digit writes wait, with a bound, until the update lock reads clear
  task automatic dwr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] s;
    int n;
    s = 8'h02;
    for (n = 0; n < 64 && s[1] !== 1'b0; n++)
      rd(8'h4d, s);
    wr(a, d);
  endtask
endmodule

// File: testbench.sv
// Self-checking bench for the I/O-mapped clock, interrupt and watchdog.
// Assumes the host model above and shortened timing parameters.
`timescale 1ns/1ps

module testbench;
  import rtc_wdog_pkg::*;
  localparam int TICK = 4;
  localparam int PULSE = 20;
  localparam int WD = 200;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic jumper = 1'b0;
  logic wd_enable = 1'b0;
  logic brst_n = 1'b1;
  io_req_s io_req;
  logic [7:0] io_rdata;
  logic rtc_irq;
  logic board_reset_req;
  logic [7:0] got;
  int err_count = 0;
  int total_checks = 0;
  int rst_hi = 0;
  int rst_base = 0;
  int hi;
  int per;
  // Digit rows: value written, value read back (field masked, jumper open in bit 7)
  logic [7:0] wv [13] = '{8'h35, 8'hf4, 8'h27, 8'h1d, 8'h03, 8'h01, 8'h08,
    8'h32, 8'h04, 8'h10, 8'h29, 8'h97, 8'h36};
  logic [7:0] ev [13] = '{8'h85, 8'h84, 8'h87, 8'h85, 8'h83, 8'h81, 8'h88,
    8'h82, 8'h84, 8'h80, 8'h89, 8'h87, 8'h86};
  // Timebase rows: control F value and expected one-second period in cycles
  logic [7:0] fv [2] = '{8'h04, 8'h0c};
  int pv [2] = '{64 * TICK, 64};
  // Rollover preset: 11:5x:58 AM; the minute units come from each call
  logic [7:0] hms [6] = '{8'h08, 8'h05, 8'h00, 8'h05, 8'h01, 8'h01};

  // 100 MHz clock
  initial forever #5 clk = ~clk;

  rtc_watchdog_io #(.TICK_CYC(TICK), .PULSE_CYC(PULSE), .WD_CYC(WD)) rtc_watchdog_io_inst (
    .clk(clk), .rstn(rstn), .io_req(io_req), .io_rdata(io_rdata),
    .config_jumper_fitted(jumper), .watchdog_enable_jumper(wd_enable),
    .board_rst_n(brst_n), .rtc_irq(rtc_irq), .board_reset_req(board_reset_req));
  io_host_model io_host_model_inst (.clk(clk), .io_req(io_req), .io_rdata(io_rdata));

  // Counts board reset cycles, so a short pulse cannot slip between checks
  always @(negedge clk) rst_hi <= rst_hi + int'(board_reset_req === 1'b1);

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
    total_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic rd(input logic [7:0] a);
    io_host_model_inst.rd(a, got);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    io_host_model_inst.wr(a, d);
  endtask

  // High time of one interrupt pulse and rise-to-rise period, bounded waits
  task automatic period(output int h, output int p);
    h = 0;
    for (int n = 0; n < 2000 && rtc_irq !== 1'b1; n++)
      @(negedge clk);
    while (rtc_irq === 1'b1 && h < 2000)
    begin
      @(negedge clk);
      h++;
    end
    p = h;
    while (rtc_irq !== 1'b1 && p < 2000)
    begin
      @(negedge clk);
      p++;
    end
  endtask

  // Presets the time halted in 12-hour test mode, runs two and a half seconds, checks the event
  task automatic rollover(input logic [7:0] ctl_e, input logic [7:0] min_u,
                          input logic [15:0] fire);
    wr(8'h4f, 8'h0b);
    wr(8'h4e, ctl_e);
    for (int i = 0; i < 6; i++)
      io_host_model_inst.dwr(8'h40 + 8'(i), (i == 2) ? min_u : hms[i]);
    wr(8'h4d, 8'h01);
    wr(8'h4f, 8'h08);
    repeat (100) @(negedge clk);
    chk("no early event", 16'h0, {15'h0, rtc_irq});
    repeat (60) @(negedge clk);
    chk("rollover event", fire, {15'h0, rtc_irq});
    wr(8'h4f, 8'h02);
  endtask

  initial
  begin
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    rd(8'h4e);
    chk("control_e reset", 8'h80, got);
    rd(8'h4f);
    chk("control_f reset", 8'h80, got);
    wr(8'h4f, 8'hf7);
    rd(8'h4f);
    chk("control_f halted", 8'h86, got);
    $display("test reset done");
    for (int i = 0; i < 13; i++)
      io_host_model_inst.dwr(8'h40 + 8'(i), wv[i]);
    wr(8'h4d, 8'h01);
    for (int i = 0; i < 13; i++)
    begin
      rd(8'h70 + 8'(i));
      chk("digit", ev[i], got);
    end
    $display("test digits done");
    // Seconds 30 while halted: rounding must clear them and bump 57 to 58
    io_host_model_inst.dwr(8'h41, 8'h03);
    io_host_model_inst.dwr(8'h40, 8'h00);
    wr(8'h4d, 8'h01);
    wr(8'h4d, 8'h08);
    repeat (600) @(posedge clk);
    rd(8'h42);
    chk("minute bumped", 8'h88, got);
    rd(8'h41);
    chk("seconds cleared", 8'h80, got);
    @(posedge clk);
    brst_n <= 1'b0;
    repeat (4) @(posedge clk);
    brst_n <= 1'b1;
    rd(8'h4b);
    chk("year kept", 8'h87, got);
    @(posedge clk);
    jumper <= 1'b1;
    repeat (3) @(posedge clk);
    rd(8'h40);
    chk("jumper fitted", 8'h00, got);
    rd(8'h85);
    chk("outside window", 8'h00, got);
    @(posedge clk);
    jumper <= 1'b0;
    $display("test round halt jumper done");
    // Prescaler cleared and running: one second later the seconds read 1
    wr(8'h4f, 8'h05);
    wr(8'h4e, 8'h06);
    repeat (300) @(posedge clk);
    rd(8'h40);
    chk("second counted", 8'h81, got);
    repeat (30) @(negedge clk);
    chk("latched irq", 8'h01, {7'h0, rtc_irq});
    rd(8'h4d);
    chk("flag pending", 8'h04, got & 8'h04);
    wr(8'h4e, 8'h07);
    repeat (2) @(negedge clk);
    chk("gated irq", 8'h00, {7'h0, rtc_irq});
    wr(8'h4e, 8'h06);
    repeat (2) @(negedge clk);
    chk("ungated irq", 8'h01, {7'h0, rtc_irq});
    wr(8'h4d, 8'h00);
    repeat (2) @(negedge clk);
    chk("flag cleared", 8'h00, {7'h0, rtc_irq});
    wr(8'h4e, 8'h04);
    for (int i = 0; i < 2; i++)
    begin
      wr(8'h4f, fv[i]);
      period(hi, per);
      period(hi, per);
      chk("pulse width", 16'(PULSE), 16'(hi));
      chk("period", 16'(pv[i]), 16'(per));
    end
    $display("test interrupt done");
    rollover(8'h0a, 8'h08, 16'h1);
    rollover(8'h0e, 8'h08, 16'h0);
    rollover(8'h0e, 8'h09, 16'h1);
    rd(8'h45);
    chk("meridiem", 8'h85, got);
    rd(8'h44);
    chk("hour units", 8'h82, got);
    $display("test rollover done");
    @(posedge clk);
    wd_enable <= 1'b1;
    rst_base = rst_hi;
    for (int i = 0; i < 6; i++)
    begin
      repeat (WD / 2) @(posedge clk);
      if (i % 2 == 0)
        rd(8'h7f);
      else
        wr(8'h4e, 8'h01);
    end
    chk("no reset while kicked", 16'h0, 16'(rst_hi - rst_base));
    repeat (WD * 3 / 4) @(posedge clk);
    brst_n <= 1'b0;
    repeat (4) @(posedge clk);
    brst_n <= 1'b1;
    repeat (WD * 3 / 4) @(posedge clk);
    chk("count cleared by reset", 16'h0, 16'(rst_hi - rst_base));
    repeat (WD) @(posedge clk);
    chk("reset pulse", 16'd16, 16'(rst_hi - rst_base));
    $display("test watchdog done");
    results();
  end

  // The run takes a few thousand cycles; this bound cuts a hang short
  initial
  begin
    repeat (20000) @(posedge clk);
    err_count++;
    results();
  end
endmodule
